// *** core/mdpsi_pkg.sv ***
/*
  Package for the multidrop symbol interface: timing figures, 5B code groups,
  transmit sequencing states and the symbol carrier struct.
  Assumes a 25 MHz system clock; all counts are derived from it.
*/
package mdpsi_pkg;

  localparam int SYS_CLK_PERIOD_NS = 40;
  localparam int SYMB_PERIOD_NS    = 400;
  localparam int SYMB_CYCLES_INT   = SYMB_PERIOD_NS / SYS_CLK_PERIOD_NS;
  localparam logic [3:0] SYMB_LAST = 4'(SYMB_CYCLES_INT - 1);
  // Five bits of two DME halves each share one symbol period
  localparam logic [3:0] HALF_BIT_CYCLES = 4'(SYMB_CYCLES_INT / 10);
  localparam int CRS_HOLD_NS       = 400;
  localparam logic [3:0] CRS_HOLD  = 4'(CRS_HOLD_NS / SYS_CLK_PERIOD_NS);

  localparam logic [4:0] SYM_SILENCE = 5'h1F;
  localparam logic [4:0] SYM_SYNC    = 5'h18;
  localparam logic [4:0] SYM_SSD     = 5'h04;
  localparam logic [4:0] SYM_ESD     = 5'h0D;
  localparam logic [4:0] SYM_ESDOK   = 5'h07;
  localparam logic [4:0] SYM_ESDERR  = 5'h11;

  // Data code groups, nibble F down to nibble 0
  localparam logic [15:0][4:0] DATA_5B = {
    5'h1D, 5'h1C, 5'h1B, 5'h1A, 5'h17, 5'h16, 5'h13, 5'h12,
    5'h0F, 5'h0E, 5'h0B, 5'h0A, 5'h15, 5'h14, 5'h09, 5'h1E};

  localparam logic       RST_LINE  = 1'b0;
  localparam logic [3:0] RST_COUNT = 4'h0;

  typedef enum logic [2:0] {
    TX_SILENT, TX_SYNC2, TX_SSD1, TX_SSD2, TX_DATA, TX_ESD_END
  } mdpsi_tx_state_e;

  typedef struct packed {
    logic       valid;
    logic [4:0] sym;
  } mdpsi_sym_s;

endpackage

// *** core/mdpsi_sync3.sv ***
/*
  Three-flop input synchroniser with agreement filter.
  Assumes the input is asynchronous to i_sys_clk; the output changes only when
  the second and third stages agree.
*/
`timescale 1ns/1ns
`default_nettype none
module mdpsi_sync3 #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_reset,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] stage2_r;
  logic [WIDTH-1:0] stage3_r;

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      meta_r   <= '0;
      stage2_r <= '0;
      stage3_r <= '0;
      o_sync   <= '0;
    end else begin
      meta_r   <= i_async;
      stage2_r <= meta_r;
      stage3_r <= stage2_r;
      if (stage2_r == stage3_r) begin
        o_sync <= stage3_r;
      end
    end
  end

endmodule
`default_nettype wire

// *** core/mdpsi_symbol_if.sv ***
/*
  Symbol interface between coding and attachment sublayers of a 10 Mb/s
  multidrop single-pair PHY: MII nibble to 5B coding, DME transmit onto the
  trunk attachment point, recovered-clock symbol receive and carrier report.
  Assumes a 25 MHz clock; the recovered line clock and received symbol lines
  arrive from the line receiver asynchronously and are synchronised here.
*/
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// R1 - Exactly one received 5B symbol is delivered per recovered clock cycle; the code delivers none while transmitting or held.
// R2 - Receive indications follow the recovered line clock, nominally 2.5 MHz.
// R3 - Every arriving symbol gives one indication, none skipped or merged; the code skips symbols while transmitting or held.
// R4 - One transmit symbol request on each symbol timer expiry, never otherwise; the code makes none while held.
// R5 - Transmit symbols come only from the permitted 5B code groups.
// R6 - Transmit symbols are 4B/5B encoded nibbles or out-of-band control codes.
// R7 - Each transmit request is DME processed and driven onto the trunk pair; SILENCE requests switch the driver off instead.
// R8 - Single shared pair, 10 Mb/s, half-duplex: no receive while transmitting.
// R9 - No auto-negotiation; link enable comes from a fixed control input.
// R10 - A management entity controls the PHY through MDIO or equivalent.
// R11 - Conditional branch runs first, then actions after the conditional block.
// R12 - Carrier reported while DME activity is present, and drives MII carrier sense.
// R13 - On transmit enable: two SYNC, two SSD replacing preamble, then data.
// R14 - Each 5-bit symbol is serialised least significant bit first.
// R15 - Symbol timer expires every 400 ns, carrying nibbles at 10 Mb/s.
module mdpsi_symbol_if (
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_reset,
  input  wire logic                 i_link_control,
  input  wire logic                 i_pcs_reset_req,
  input  wire logic                 i_tx_en,
  input  wire logic                 i_tx_er,
  input  wire logic [3:0]           i_txd,
  input  wire logic                 i_rx_clk,
  input  wire logic [4:0]           i_rx_sym,
  input  wire logic                 i_trunk_rx,
  output logic                      o_trunk_tx,
  output logic                      o_trunk_tx_oe,
  output logic                      o_crs,
  output var mdpsi_pkg::mdpsi_sym_s o_tx_req,
  output var mdpsi_pkg::mdpsi_sym_s o_rx_ind
);

  logic                        rx_clk_s;
  logic [4:0]                  rx_sym_s;
  logic                        trunk_rx_s;
  logic                        rx_clk_prev_r;
  logic                        trunk_prev_r;
  logic [3:0]                  crs_cnt_r;
  logic [3:0]                  symb_cnt_r;
  logic                        symb_exp;
  logic                        pcs_hold;
  mdpsi_pkg::mdpsi_tx_state_e  state_r;
  logic                        err_r;
  mdpsi_pkg::mdpsi_sym_s       tx_req_r;
  mdpsi_pkg::mdpsi_sym_s       rx_ind_r;
  logic [4:0]                  shift_r;
  logic [3:0]                  half_r;
  logic [3:0]                  half_nxt;
  logic                        line_r;
  logic                        oe_r;
  logic                        crs_r;

  mdpsi_sync3 #(.WIDTH(1)) u_sync_rx_clk (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_async   (i_rx_clk),
    .o_sync    (rx_clk_s)
  );

  mdpsi_sync3 #(.WIDTH(5)) u_sync_rx_sym (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_async   (i_rx_sym),
    .o_sync    (rx_sym_s)
  );

  mdpsi_sync3 #(.WIDTH(1)) u_sync_trunk (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_async   (i_trunk_rx),
    .o_sync    (trunk_rx_s)
  );

  // Management reset request or link disable parks all coding functions
  assign pcs_hold = i_pcs_reset_req || !i_link_control; // R9 R10

  // Symbol timer runs freely so request spacing never drifts
  assign symb_exp = (symb_cnt_r == mdpsi_pkg::SYMB_LAST); // R15

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      symb_cnt_r <= mdpsi_pkg::RST_COUNT;
    end else if (symb_exp) begin
      symb_cnt_r <= mdpsi_pkg::RST_COUNT;
    end else begin
      symb_cnt_r <= symb_cnt_r + 4'h1;
    end
  end

  // Transmit coding: one request per timer expiry unless held, symbols from the 5B set only
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      state_r  <= mdpsi_pkg::TX_SILENT;
      err_r    <= 1'b0;
      tx_req_r <= '0;
    end else begin
      tx_req_r.valid <= 1'b0;
      if (pcs_hold) begin
        state_r <= mdpsi_pkg::TX_SILENT;
        err_r   <= 1'b0;
      end else if (symb_exp) begin
        tx_req_r.valid <= 1'b1; // R4
        case (state_r)
          mdpsi_pkg::TX_SILENT: begin
            if (i_tx_en) begin
              tx_req_r.sym <= mdpsi_pkg::SYM_SYNC; // R13
              err_r        <= 1'b0;
              state_r      <= mdpsi_pkg::TX_SYNC2;
            end else begin
              tx_req_r.sym <= mdpsi_pkg::SYM_SILENCE;
            end
          end
          mdpsi_pkg::TX_SYNC2: begin
            tx_req_r.sym <= mdpsi_pkg::SYM_SYNC; // R13
            state_r      <= mdpsi_pkg::TX_SSD1;
          end
          mdpsi_pkg::TX_SSD1: begin
            tx_req_r.sym <= mdpsi_pkg::SYM_SSD; // R13
            state_r      <= mdpsi_pkg::TX_SSD2;
          end
          mdpsi_pkg::TX_SSD2: begin
            tx_req_r.sym <= mdpsi_pkg::SYM_SSD; // R13
            state_r      <= mdpsi_pkg::TX_DATA;
          end
          mdpsi_pkg::TX_DATA: begin
            if (i_tx_en) begin
              tx_req_r.sym <= mdpsi_pkg::DATA_5B[i_txd]; // R5 R6
              if (i_tx_er) begin
                err_r <= 1'b1;
              end
            end else begin
              tx_req_r.sym <= mdpsi_pkg::SYM_ESD; // R6
              state_r      <= mdpsi_pkg::TX_ESD_END;
            end
          end
          mdpsi_pkg::TX_ESD_END: begin
            if (err_r) begin
              tx_req_r.sym <= mdpsi_pkg::SYM_ESDERR; // R11
            end else begin
              tx_req_r.sym <= mdpsi_pkg::SYM_ESDOK; // R11
            end
            state_r <= mdpsi_pkg::TX_SILENT; // R11
          end
          default: begin
            tx_req_r.sym <= mdpsi_pkg::SYM_SILENCE;
            state_r      <= mdpsi_pkg::TX_SILENT;
          end
        endcase
      end
    end
  end

  assign half_nxt = half_r + mdpsi_pkg::HALF_BIT_CYCLES;

  // DME: a transition opens every bit, a mid-bit transition marks a one.
  // Half-bit is one clock, so each request fills exactly one symbol period.
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      shift_r <= mdpsi_pkg::SYM_SILENCE;
      half_r  <= mdpsi_pkg::RST_COUNT;
      line_r  <= mdpsi_pkg::RST_LINE;
      oe_r    <= 1'b0;
    end else if (tx_req_r.valid) begin
      shift_r <= tx_req_r.sym;
      half_r  <= mdpsi_pkg::RST_COUNT;
      if (tx_req_r.sym == mdpsi_pkg::SYM_SILENCE) begin
        oe_r <= 1'b0; // R8
      end else begin
        oe_r   <= 1'b1; // R7
        line_r <= !line_r; // R7
      end
    end else if (oe_r) begin
      half_r <= half_nxt;
      if (!half_nxt[0] || shift_r[half_nxt[3:1]]) begin
        line_r <= !line_r; // R14
      end
    end
  end

  // Carrier holds while line transitions keep arriving
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      trunk_prev_r <= mdpsi_pkg::RST_LINE;
      crs_cnt_r    <= mdpsi_pkg::RST_COUNT;
      crs_r        <= 1'b0;
    end else begin
      trunk_prev_r <= trunk_rx_s;
      if (trunk_rx_s != trunk_prev_r) begin
        crs_cnt_r <= mdpsi_pkg::CRS_HOLD; // R12
      end else if (crs_cnt_r != mdpsi_pkg::RST_COUNT) begin
        crs_cnt_r <= crs_cnt_r - 4'h1;
      end
      crs_r <= (crs_cnt_r != mdpsi_pkg::RST_COUNT) && i_link_control; // R12
    end
  end

  // One indication per recovered clock rising edge; own transmit or a hold blanks it
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      rx_clk_prev_r <= 1'b0;
      rx_ind_r      <= '0;
    end else begin
      rx_clk_prev_r  <= rx_clk_s;
      rx_ind_r.valid <= 1'b0;
      if (rx_clk_s && !rx_clk_prev_r) begin // R2
        if (!oe_r && !pcs_hold) begin // R8
          rx_ind_r.valid <= 1'b1; // R1 R3
          rx_ind_r.sym   <= rx_sym_s; // R1
        end
      end
    end
  end

  assign o_trunk_tx    = line_r;
  assign o_trunk_tx_oe = oe_r;
  assign o_crs         = crs_r;
  assign o_tx_req      = tx_req_r;
  assign o_rx_ind      = rx_ind_r;

endmodule
`default_nettype wire

// *** tb/mdpsi_chk.sv ***
/* Port assertions for the multidrop symbol interface.
   Bound to mdpsi_symbol_if; one 25 MHz clock domain. */
`timescale 1ns/1ns
`default_nettype none
module mdpsi_chk (
  input wire logic                  i_sys_clk,
  input wire logic                  i_reset,
  input wire logic                  i_link_control,
  input wire logic                  i_pcs_reset_req,
  input wire logic                  i_trunk_rx,
  input wire logic                  o_trunk_tx,
  input wire logic                  o_trunk_tx_oe,
  input wire logic                  o_crs,
  input wire mdpsi_pkg::mdpsi_sym_s o_tx_req,
  input wire mdpsi_pkg::mdpsi_sym_s o_rx_ind
);
  logic [4:0] quiet_r;
  logic       line_r;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  // Cycles since the line last moved, saturating
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      quiet_r <= 5'h00;
      line_r  <= 1'b0;
    end else begin
      line_r  <= i_trunk_rx;
      quiet_r <= (i_trunk_rx != line_r) ? 5'h00 : quiet_r + {4'h0, quiet_r != 5'h1F};
    end
  end
  chk_req_period: assert property (o_tx_req.valid |-> ##10 (o_tx_req.valid
    || $past(i_pcs_reset_req) || !$past(i_link_control))) else $error("request period broken");
  chk_hold_quiet: assert property (i_pcs_reset_req || !i_link_control
    |=> !o_tx_req.valid) else $error("request while held");
  chk_crs_link: assert property (!i_link_control |=> !o_crs)
    else $error("carrier with link disabled");
  chk_req_quiet: assert property (o_tx_req.valid |=> !o_tx_req.valid [*8])
    else $error("extra request");
  chk_code_set: assert property (o_tx_req.valid |-> o_tx_req.sym inside {5'h1E, 5'h09,
    5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B,
    5'h1C, 5'h1D, 5'h18, 5'h04, 5'h0D, 5'h07, 5'h11, 5'h1F}) else $error("illegal code");
  chk_dme_start: assert property (o_tx_req.valid && o_tx_req.sym != 5'h1F |=>
    o_trunk_tx_oe && o_trunk_tx != $past(o_trunk_tx)) else $error("no DME start");
  chk_lsb_first: assert property (o_tx_req.valid && o_tx_req.sym != 5'h1F |->
    ##2 (o_trunk_tx != $past(o_trunk_tx)) == o_tx_req.sym[0]) else $error("bit order");
  chk_silence_off: assert property (o_tx_req.valid && o_tx_req.sym == 5'h1F
    |=> !o_trunk_tx_oe) else $error("driving in silence");
  chk_half_duplex: assert property (o_trunk_tx_oe && $past(o_trunk_tx_oe)
    && $past(o_trunk_tx_oe, 2) |-> !o_rx_ind.valid) else $error("receive while sending");
  chk_rx_single: assert property (o_rx_ind.valid |=> !o_rx_ind.valid [*6])
    else $error("merged indications");
  chk_frame_start: assert property (o_tx_req.valid && o_tx_req.sym == 5'h18
    && $past(o_tx_req.sym) == 5'h1F |-> ##10 o_tx_req.sym == 5'h18 ##10 o_tx_req.sym
    == 5'h04 ##10 o_tx_req.sym == 5'h04) else $error("bad frame start");
  chk_crs_rise: assert property (i_link_control && i_trunk_rx != $past(i_trunk_rx)
    |-> ##[2:9] o_crs) else $error("carrier missed");
  chk_crs_idle: assert property (quiet_r >= 5'h14 |-> !o_crs)
    else $error("carrier on quiet line");
endmodule
bind mdpsi_symbol_if mdpsi_chk u_chk (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
  .i_link_control(i_link_control), .i_pcs_reset_req(i_pcs_reset_req),
  .i_trunk_rx(i_trunk_rx), .o_trunk_tx(o_trunk_tx),
  .o_trunk_tx_oe(o_trunk_tx_oe), .o_crs(o_crs), .o_tx_req(o_tx_req), .o_rx_ind(o_rx_ind));
`default_nettype wire

// *** tb/mdpsi_line_model.sv ***
/* Far-side station: recovered clock, received symbols and line level.
   Driven by bench task calls; its clock stands still between bursts. */
`timescale 1ns/1ns
`default_nettype none
module mdpsi_line_model (
  output logic       o_rx_clk,
  output logic [4:0] o_rx_sym,
  output logic       o_line
);
  initial begin
    o_rx_clk = 1'b0;
    o_rx_sym = 5'h00;
    o_line   = 1'b0;
  end
  // One symbol per 320 ns clock cycle, stable around the rising edge
  task automatic send(input logic [4:0] s);
    o_rx_sym = s;
    repeat (2) begin
      #80;
      o_line = ~o_line;
    end
    o_rx_clk = 1'b1;
    repeat (2) begin
      #80;
      o_line = ~o_line;
    end
    o_rx_clk = 1'b0;
  endtask
  // Released symbol lines flip; the biased pair rests low
  task automatic idle;
    o_rx_sym = ~o_rx_sym;
    o_line   = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** tb/multidrop_pcs_pma_symbol_interface_test.sv ***
/* Self-checking bench for mdpsi_symbol_if with a far-side line model.
   Assumes the checker is bound by its own file. */
`timescale 1ns/1ns
`default_nettype none
module multidrop_pcs_pma_symbol_interface_test;
  logic                  sys_clk = 1'b0;
  logic                  reset, tx_en, tx_er, rx_clk, trunk_rx, trunk_tx, trunk_oe, crs;
  logic [3:0]            txd;
  logic [4:0]            rx_sym;
  logic                  link_ctl   = 1'b1;
  logic                  pcs_rst    = 1'b0;
  mdpsi_pkg::mdpsi_sym_s tx_req, rx_ind;
  int                    n_mismatch = 0;
  int                    num_checks = 0;
  int                    cycles     = 0;
  int                    nreq       = 0;
  logic [4:0]            rxq[$];
  always #20 sys_clk = ~sys_clk;
  mdpsi_line_model line (.o_rx_clk(rx_clk), .o_rx_sym(rx_sym), .o_line(trunk_rx));
  mdpsi_symbol_if uut (.i_sys_clk(sys_clk), .i_reset(reset), .i_link_control(link_ctl),
    .i_pcs_reset_req(pcs_rst), .i_tx_en(tx_en), .i_tx_er(tx_er), .i_txd(txd),
    .i_rx_clk(rx_clk), .i_rx_sym(rx_sym), .i_trunk_rx(trunk_rx), .o_trunk_tx(trunk_tx),
    .o_trunk_tx_oe(trunk_oe), .o_crs(crs), .o_tx_req(tx_req), .o_rx_ind(rx_ind));
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic ok, input string m);
    num_checks++;
    if (!ok) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  // Timeout and capture of every received indication
  always @(negedge sys_clk) begin
    cycles++;
    if (rx_ind.valid === 1'b1) rxq.push_back(rx_ind.sym);
    if (tx_req.valid === 1'b1) nreq++;
    if (cycles == 3000) begin
      n_mismatch++;
      report_and_stop;
    end
  end
  task get_req(output logic [4:0] s, output int k);
    for (k = 0; k < 12 && tx_req.valid !== 1'b1; k++) @(negedge sys_clk);
    chk(tx_req.valid === 1'b1, "no transmit request");
    s = tx_req.sym;
    @(negedge sys_clk);
  endtask
  task t_idle;
    logic [4:0] s;
    int         k;
    get_req(s, k);
    get_req(s, k);
    chk(k === 9, "request spacing");
    chk(s === mdpsi_pkg::SYM_SILENCE && trunk_oe === 1'b0, "idle request");
  endtask
  // Management reset, then link disable while a far station talks: all stays parked
  task t_hold;
    logic [4:0] s;
    int         k;
    int         n0;
    int         r0;
    get_req(s, k);
    pcs_rst = 1'b1;
    n0      = nreq;
    repeat (30) @(negedge sys_clk);
    chk(nreq === n0, "request under management reset");
    pcs_rst  = 1'b0;
    link_ctl = 1'b0;
    r0       = rxq.size();
    for (int i = 0; i < 2; i++) line.send(5'h0F);
    chk(crs === 1'b0, "carrier with link disabled");
    line.idle();
    repeat (20) @(negedge sys_clk);
    chk(nreq === n0 && rxq.size() === r0, "activity with link disabled");
    link_ctl = 1'b1;
    get_req(s, k);
    chk(s === mdpsi_pkg::SYM_SILENCE, "first request after hold");
  endtask
  // Follows one symbol on the pair from its first mid-bit to its last mid-bit;
  // returns on the cycle that carries the next request
  task dme_chk(input logic [4:0] s);
    logic l;
    l = trunk_tx;
    for (int h = 2; h <= 10; h++) begin
      @(negedge sys_clk);
      chk(trunk_oe === 1'b1 && ((trunk_tx !== l) === (h[0] ? 1'b1 : s[h / 2 - 1])),
        "DME half bit");
      l = trunk_tx;
    end
  endtask
  task frame(input int n, input logic er);
    logic [4:0] s;
    logic [4:0] e[$];
    int         k;
    int         r0;
    e = {mdpsi_pkg::SYM_SYNC, mdpsi_pkg::SYM_SYNC, mdpsi_pkg::SYM_SSD, mdpsi_pkg::SYM_SSD};
    for (int i = 0; i < n; i++) e.push_back(mdpsi_pkg::DATA_5B[i]);
    e.push_back(mdpsi_pkg::SYM_ESD);
    e.push_back(er ? mdpsi_pkg::SYM_ESDERR : mdpsi_pkg::SYM_ESDOK);
    e.push_back(mdpsi_pkg::SYM_SILENCE);
    get_req(s, k);
    tx_en = 1'b1;
    txd   = 4'h5;
    r0    = rxq.size();
    // Far station talks over our frame on purpose
    fork
      begin
        #600;
        for (int i = 0; i < 3; i++) line.send(5'h09);
        line.idle();
      end
    join_none
    for (int i = 0; i < e.size(); i++) begin
      get_req(s, k);
      chk(s === e[i], "transmit symbol");
      txd   = (i < 3) ? 4'h5 : 4'(i - 3);
      tx_en = i < n + 3;
      tx_er = er && i == 3;
      if (e[i] !== mdpsi_pkg::SYM_SILENCE) dme_chk(e[i]);
    end
    chk(rxq.size() === r0, "indication while transmitting");
  endtask
  task t_rx;
    rxq.delete();
    for (int i = 0; i < 4; i++) line.send(5'(5'h0A + 5 * i));
    chk(crs === 1'b1, "carrier during burst");
    line.idle();
    repeat (20) @(negedge sys_clk);
    chk(crs === 1'b0, "carrier after burst");
    chk(rxq.size() === 4, "indication count");
    foreach (rxq[i]) chk(rxq[i] === 5'(5'h0A + 5 * i), "received symbol");
  endtask
  initial begin
    reset = 1'b1;
    tx_en = 1'b0;
    tx_er = 1'b0;
    txd   = 4'h0;
    repeat (5) @(negedge sys_clk);
    reset = 1'b0;
    t_idle();
    t_hold();
    frame(16, 1'b0);
    frame(2, 1'b1);
    t_rx();
    report_and_stop;
  end
endmodule
`default_nettype wire
